/* design/ueig_gate.sv */
// usb error interrupt gating with axi4-lite register slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module ueig_gate
	import ueig_pkg::*;
#(
	parameter int TURN_BITS = TURN_IDLE_BITS
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// error events from the serial interface engine
	input wire ueig_sie_evt_t sie_events,
	// bus timing for the turnaround watch
	input wire logic eop_seen,
	input wire logic response_start,
	input wire logic bit_tick,
	input wire logic line_idle,
	// interrupt outputs
	output logic usb_error_summary,
	output logic usb_irq
);

	localparam int CNT_W = $clog2(TURN_BITS + 1);

	// write channel state
	logic aw_have, next_aw_have;
	logic [7:0] aw_addr, next_aw_addr;
	logic w_have, next_w_have;
	logic [7:0] w_data, next_w_data;
	logic w_lane0, next_w_lane0;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic do_write;
	logic st_wr;
	// read channel state
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [7:0] rd_byte;
	logic rd_ok;
	// registers
	logic [7:0] err_enable, next_err_enable;
	logic [7:0] irq_enable, next_irq_enable;
	logic [7:0] err_flags;
	logic [7:0] evt_vec;
	logic [7:0] clr_vec;
	logic next_summary, next_irq;
	// turnaround watch
	logic armed, next_armed;
	logic [CNT_W-1:0] turn_cnt, next_turn_cnt;
	logic turn_fire;

	// channel readies
	assign awready = !aw_have;
	assign wready = !w_have;
	assign arready = !rvalid;
	assign do_write = aw_have && w_have && !bvalid;
	// status register write with lane 0 on, watched by the checks
	assign st_wr = do_write && w_lane0 && aw_addr == OFF_ERR_STATUS;

	// write channel: address and data taken in either order
	always_comb begin
		next_aw_have = aw_have;
		next_aw_addr = aw_addr;
		next_w_have = w_have;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (awvalid && awready) begin
			next_aw_have = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_w_have = 1'b1;
			next_w_data = wdata[7:0];
			next_w_lane0 = wstrb[0];
		end
		if (do_write) begin
			next_aw_have = 1'b0;
			next_w_have = 1'b0;
			next_bvalid = 1'b1;
			case (aw_addr)
				OFF_ERR_STATUS, OFF_ERR_ENABLE,
				OFF_IRQ_STATUS, OFF_IRQ_ENABLE: begin
					next_bresp = RESP_OKAY;
				end
				default: begin
					next_bresp = RESP_SLVERR;
				end
			endcase
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
	end

	// write channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			aw_addr <= 8'h00;
			w_have <= 1'b0;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			aw_have <= next_aw_have;
			aw_addr <= next_aw_addr;
			w_have <= next_w_have;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
		end
	end

	// software state: enables; status clears by writing zero
	always_comb begin
		next_err_enable = err_enable;
		next_irq_enable = irq_enable;
		clr_vec = 8'h00;
		if (do_write && w_lane0) begin
			case (aw_addr)
				OFF_ERR_ENABLE: begin
					next_err_enable = w_data & ERR_IMPL_MASK;
				end
				OFF_IRQ_ENABLE: begin
					next_irq_enable = w_data & IRQ_IMPL_MASK;
				end
				OFF_ERR_STATUS: begin
					clr_vec = ~w_data & ERR_IMPL_MASK;
				end
				default: begin
					clr_vec = 8'h00;
				end
			endcase
		end
	end

	// enable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_enable <= ERR_ENABLE_RST;
			irq_enable <= IRQ_ENABLE_RST;
		end else begin
			err_enable <= next_err_enable;
			irq_enable <= next_irq_enable;
		end
	end

	// turnaround watch: count idle bit times after eop
	always_comb begin
		next_armed = armed;
		next_turn_cnt = turn_cnt;
		turn_fire = 1'b0;
		if (response_start) begin
			next_armed = 1'b0;
			next_turn_cnt = '0;
		end else if (eop_seen) begin
			next_armed = 1'b1;
			next_turn_cnt = '0;
		end else if (armed && bit_tick && line_idle) begin
			if (turn_cnt == CNT_W'(TURN_BITS)) begin
				turn_fire = 1'b1;
				next_armed = 1'b0;
				next_turn_cnt = '0;
			end else begin
				next_turn_cnt = turn_cnt + 1'b1;
			end
		end
	end

	// turnaround registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed <= 1'b0;
			turn_cnt <= '0;
		end else begin
			armed <= next_armed;
			turn_cnt <= next_turn_cnt;
		end
	end

	// event vector in register layout, independent of enables
	always_comb begin
		evt_vec = 8'h00;
		evt_vec[BIT_BIT_STUFF] = sie_events.bit_stuff;
		evt_vec[BIT_TURNAROUND] = turn_fire;
		evt_vec[BIT_BYTE_ALIGN] = sie_events.byte_align;
		evt_vec[BIT_DATA_CRC] = sie_events.data_crc;
		evt_vec[BIT_TOKEN_CRC] = sie_events.token_crc;
		evt_vec[BIT_PACKET_ID] = sie_events.packet_id;
	end

	// sticky flags for implemented bits, others read zero
	for (genvar i = 0; i < 8; i++) begin : g_flag
		if (ERR_IMPL_MASK[i]) begin : g_impl
			ueig_flag_bit u_flag (
				.aclk(aclk),
				.aresetn(aresetn),
				.set(evt_vec[i]),
				.clr(clr_vec[i]),
				.q(err_flags[i])
			);
		end else begin : g_none
			assign err_flags[i] = 1'b0;
		end
	end

	// summary and interrupt: gated OR of current flags
	always_comb begin
		next_summary = |(err_flags & err_enable);
		next_irq = next_summary && irq_enable[BIT_SUMMARY];
	end

	// summary registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			usb_error_summary <= 1'b0;
			usb_irq <= 1'b0;
		end else begin
			usb_error_summary <= next_summary;
			usb_irq <= next_irq;
		end
	end

	// read mux, summary bit is status only
	always_comb begin
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		case (araddr)
			OFF_ERR_STATUS: begin
				rd_byte = err_flags;
			end
			OFF_ERR_ENABLE: begin
				rd_byte = err_enable;
			end
			OFF_IRQ_STATUS: begin
				rd_byte[BIT_SUMMARY] = usb_error_summary;
			end
			OFF_IRQ_ENABLE: begin
				rd_byte = irq_enable;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	// read channel next values
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rdata = {24'h00_0000, rd_byte};
			next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	// read channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// checks on the gating and flag behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_enable_write;
		do_write && w_lane0 && aw_addr == OFF_ERR_ENABLE;
	endsequence

	sequence s_status_write;
		st_wr;
	endsequence

	a_summary_follows: assert property (
		##1 usb_error_summary == $past(|(err_flags & err_enable)))
		else $error("summary does not follow enabled flags");

	a_mask_blocks: assert property (
		(err_enable == 8'h00) ##1 (err_enable == 8'h00) |-> !usb_error_summary)
		else $error("summary set with all enables clear");

	a_flag_sets: assert property (
		evt_vec[BIT_PACKET_ID] |=> err_flags[BIT_PACKET_ID])
		else $error("error event did not set its flag");

	a_enable_layout: assert property (
		s_enable_write |=> err_enable == ($past(w_data) & 8'h9F))
		else $error("enable register write mismatch");

	a_unimpl_zero: assert property (
		err_enable[6:5] == 2'b00 && err_flags[6:5] == 2'b00)
		else $error("unimplemented bits not zero");

	a_enable_reset: assert property (
		$rose(aresetn) |-> err_enable == 8'h00)
		else $error("enables not zero after reset");

	a_flag_sticky: assert property (
		err_flags[BIT_DATA_CRC] && !(st_wr && !w_data[BIT_DATA_CRC])
		|=> err_flags[BIT_DATA_CRC])
		else $error("flag dropped without a zero write");

	a_flag_clear: assert property (
		s_status_write
		##0 (!w_data[BIT_BIT_STUFF] && !evt_vec[BIT_BIT_STUFF])
		|=> !err_flags[BIT_BIT_STUFF])
		else $error("zero write did not clear flag");

	a_turn_fire: assert property (
		armed && bit_tick && line_idle && !response_start && !eop_seen
		&& turn_cnt == CNT_W'(TURN_BITS) |=> err_flags[BIT_TURNAROUND])
		else $error("turnaround flag not raised");

	a_turn_early: assert property (
		eop_seen && !response_start
		##1 (!turn_fire && !response_start) [*8]
		|-> armed)
		else $error("turnaround watch ended early");

	a_bvalid_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");

endmodule // ueig_gate

/* design/ueig_pkg.sv */
// package of constants and carrier types for the usb error interrupt gating
// Functional notes
// - an enabled error flag feeds the summary flag; a disabled one does not.
// - error flags set on their conditions whatever the enable bits say.
// - enables: bit stuff 7, turnaround 4, byte align 3, crc16 2, crc5 1, pid 0.
// - enable bits 6 and 5 read zero and ignore writes.
// - implemented enable bits are read/write, one enables, reset to zero.
// - summary flag is the OR of enabled flags, read only to software.
// - flags set on detection and stay set until software writes zero.
// - turnaround flag rises after more than sixteen idle bit times past eop.
package ueig_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFF_ERR_STATUS = 8'h00;
	localparam logic [7:0] OFF_ERR_ENABLE = 8'h04;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0C;

	// error flag and enable bit positions, same layout in both registers
	localparam int BIT_BIT_STUFF = 7;
	localparam int BIT_TURNAROUND = 4;
	localparam int BIT_BYTE_ALIGN = 3;
	localparam int BIT_DATA_CRC = 2;
	localparam int BIT_TOKEN_CRC = 1;
	localparam int BIT_PACKET_ID = 0;
	localparam logic [7:0] ERR_IMPL_MASK = 8'h9F;

	// top level status and enable: summary flag position
	localparam int BIT_SUMMARY = 1;
	localparam logic [7:0] IRQ_IMPL_MASK = 8'h02;

	// reset values
	localparam logic [7:0] ERR_STATUS_RST = 8'h00;
	localparam logic [7:0] ERR_ENABLE_RST = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;

	// idle bit times allowed after an end of packet
	localparam int TURN_IDLE_BITS = 16;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// error events from the serial interface engine, one-cycle pulses
	typedef struct packed {
		logic bit_stuff;
		logic byte_align;
		logic data_crc;
		logic token_crc;
		logic packet_id;
	} ueig_sie_evt_t;

endpackage

/* design/ueig_flag_bit.sv */
// one sticky error flag, set wins over clear
`timescale 1ns/100ps
module ueig_flag_bit
	import ueig_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// set and clear strobes
	input wire logic set,
	input wire logic clr,
	// flag state
	output logic q
);

	logic next_q;

	// next value: a set in the clear cycle is kept
	always_comb begin
		next_q = q;
		if (set) begin
			next_q = 1'b1;
		end else if (clr) begin
			next_q = 1'b0;
		end
	end

	// register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

endmodule // ueig_flag_bit

/* tb/ueig_sie_model.sv */
// serial engine stand-in: error pulses and bus timing strobes
`timescale 1ns/100ps
module ueig_sie_model
	import ueig_pkg::*;
(
	// clock
	input wire logic aclk,
	// events and bus timing toward the gate
	output ueig_sie_evt_t sie_events,
	output logic eop_seen,
	output logic response_start,
	output logic bit_tick,
	output logic line_idle
);
	// quiet outputs at start
	initial begin
		sie_events = '0;
		eop_seen = 1'b0;
		response_start = 1'b0;
		bit_tick = 1'b0;
		line_idle = 1'b0;
	end
	// one-cycle error pulse
	task automatic pulse(input ueig_sie_evt_t e);
		@(posedge aclk);
		sie_events <= e;
		@(posedge aclk);
		sie_events <= '0;
	endtask
	// end of packet or start of reply strobe
	task automatic mark(input logic is_eop);
		@(posedge aclk);
		eop_seen <= is_eop;
		response_start <= !is_eop;
		@(posedge aclk);
		eop_seen <= 1'b0;
		response_start <= 1'b0;
	endtask
	// one bit time, idle or busy, then slow gap
	task automatic tick(input logic idle, input int gap);
		@(posedge aclk);
		bit_tick <= 1'b1;
		line_idle <= idle;
		@(posedge aclk);
		bit_tick <= 1'b0;
		repeat (gap) @(posedge aclk);
	endtask
endmodule // ueig_sie_model

/* tb/usb_error_interrupt_gating_tb.sv */
// self-checking bench for the usb error interrupt gating
`timescale 1ns/100ps
module usb_error_interrupt_gating_tb
	import ueig_pkg::*;
();
	localparam int TB_TURN = 2;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, summ, irq, exp1;
	logic eop, rsp, tick, idle;
	logic [7:0] awaddr, araddr, en, seed;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [3:0] wstrb;
	ueig_sie_evt_t evts, ev;
	int fails, n_compared, i;

	// device under test, short turnaround count
	ueig_gate #(.TURN_BITS(TB_TURN)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .sie_events(evts), .eop_seen(eop),
		.response_start(rsp), .bit_tick(tick), .line_idle(idle),
		.usb_error_summary(summ), .usb_irq(irq)
	);
	// far side model
	ueig_sie_model i_sie (
		.aclk(aclk), .sie_events(evts), .eop_seen(eop),
		.response_start(rsp), .bit_tick(tick), .line_idle(idle)
	);

	// 100 ns clock
	always #50 aclk = ~aclk;

	// random source
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	// status bits expected from an event pulse
	function automatic logic [7:0] flags_of(input ueig_sie_evt_t e);
		return {e.bit_stuff, 3'h0, e.byte_align, e.data_crc, e.token_crc,
			e.packet_id};
	endfunction
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
			fails++;
		end
	endtask
	// verdict and end of run
	task automatic complete_run();
		$display("compared %0d, wrong %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// a bus answer that never came
	task automatic hang();
		fails++;
		$display("wrong value at %0t: no bus answer", $time);
		complete_run();
	endtask
	// axi write of one register
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 100) hang();
		chk(32'(bresp), 32'(er));
	endtask
	// axi read of one register
	task automatic rd(input logic [7:0] a, input logic [7:0] ed,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (n == 100) hang();
		chk(rdata, {24'h00_0000, ed});
		chk(32'(rresp), 32'(er));
	endtask

	// main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		fails = 0;
		n_compared = 0;
		seed = 8'h44;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values and register layout
		rd(OFF_ERR_STATUS, ERR_STATUS_RST, RESP_OKAY);
		rd(OFF_ERR_ENABLE, ERR_ENABLE_RST, RESP_OKAY);
		rd(OFF_IRQ_ENABLE, IRQ_ENABLE_RST, RESP_OKAY);
		wr(OFF_ERR_ENABLE, 8'hFF, RESP_OKAY);
		rd(OFF_ERR_ENABLE, ERR_IMPL_MASK, RESP_OKAY);
		wr(8'h10, 8'hFF, RESP_SLVERR);
		rd(8'h10, 8'h00, RESP_SLVERR);
		wr(OFF_IRQ_STATUS, 8'hFF, RESP_OKAY);
		rd(OFF_IRQ_STATUS, 8'h00, RESP_OKAY);
		wr(OFF_IRQ_ENABLE, 8'hFF, RESP_OKAY);
		rd(OFF_IRQ_ENABLE, IRQ_IMPL_MASK, RESP_OKAY);
		// random events against random enables, corners first
		for (i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			en = (i == 0) ? 8'h60 : (i == 1) ? 8'hFF : seed;
			seed = lfsr(seed);
			ev = (i < 2) ? 5'h1F : seed[4:0];
			wr(OFF_ERR_ENABLE, en, RESP_OKAY);
			i_sie.pulse(ev);
			rd(OFF_ERR_STATUS, flags_of(ev), RESP_OKAY);
			exp1 = |(flags_of(ev) & en);
			chk(32'(summ), 32'(exp1));
			chk(32'(irq), 32'(exp1));
			wr(OFF_ERR_STATUS, 8'hFF, RESP_OKAY);
			rd(OFF_ERR_STATUS, flags_of(ev), RESP_OKAY);
			wr(OFF_ERR_ENABLE, 8'h00, RESP_OKAY);
			@(posedge aclk);
			chk(32'(summ), 32'h0000_0000);
			wr(OFF_ERR_STATUS, 8'h00, RESP_OKAY);
			rd(OFF_ERR_STATUS, 8'h00, RESP_OKAY);
		end
		// turnaround watch fires only past the idle limit
		wr(OFF_ERR_ENABLE, 8'h10, RESP_OKAY);
		i_sie.mark(1'b1);
		for (i = 0; i < TB_TURN; i++) i_sie.tick(1'b1, i);
		i_sie.tick(1'b0, 3);
		rd(OFF_ERR_STATUS, 8'h00, RESP_OKAY);
		i_sie.tick(1'b1, 0);
		repeat (2) @(posedge aclk);
		rd(OFF_ERR_STATUS, 8'h10, RESP_OKAY);
		chk(32'(summ), 32'h0000_0001);
		rd(OFF_IRQ_STATUS, 8'h02, RESP_OKAY);
		wr(OFF_ERR_STATUS, 8'h00, RESP_OKAY);
		// a reply in time disarms the watch
		i_sie.mark(1'b1);
		i_sie.tick(1'b1, 0);
		i_sie.mark(1'b0);
		for (i = 0; i < TB_TURN + 2; i++) i_sie.tick(1'b1, 0);
		rd(OFF_ERR_STATUS, 8'h00, RESP_OKAY);
		// a write with lane 0 off leaves the register alone
		wstrb <= 4'h0;
		wr(OFF_ERR_ENABLE, 8'h00, RESP_OKAY);
		wstrb <= 4'hF;
		rd(OFF_ERR_ENABLE, 8'h10, RESP_OKAY);
		// reset in mid run clears the enables and the flags
		wr(OFF_ERR_ENABLE, 8'hFF, RESP_OKAY);
		i_sie.pulse(5'h1F);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_ERR_ENABLE, 8'h00, RESP_OKAY);
		rd(OFF_ERR_STATUS, ERR_STATUS_RST, RESP_OKAY);
		chk(32'(summ), 32'h0000_0000);
		// top enable back at zero keeps the interrupt low
		wr(OFF_ERR_ENABLE, 8'hFF, RESP_OKAY);
		i_sie.pulse(5'h01);
		rd(OFF_ERR_STATUS, 8'h01, RESP_OKAY);
		chk(32'(summ), 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		complete_run();
	end
endmodule // usb_error_interrupt_gating_tb
